// ---- ppx_host.sv ----
// parallel port host handshake: cpu register port and 1284 line control
`timescale 1ns/1ps
`default_nettype none
module ppx_host (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // cpu register port
  input  wire logic       parallel_port_select_n,
  input  wire logic [2:0] register_select_lines,
  input  wire logic       cpu_wr_n,
  input  wire logic       cpu_rd_n,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  output logic            bus_buffer_dir,
  // peripheral lines
  input  wire logic       peripheral_ack,
  input  wire logic       busy,
  input  wire logic [7:0] pd_in,
  output logic      [7:0] pd_out,
  output logic            pd_oe,
  output logic            strobe_n,
  output logic            host_feed_request_n,
  output logic            host_select_request
);
  import ppx_pkg::*;

  ppx_state_t       state_r;
  ppx_mode_t        mode_r;
  logic             dir_r;
  logic             tag_r;
  logic             rxv_r;
  logic             irq_r;
  logic             cmd_r;
  logic             neg_done_r;
  logic             ack_d_r;
  logic [7:0]       rx_r;
  logic [CNT_W-1:0] cnt_r;
  logic             ack_s;
  logic             ack_n_s;
  logic             busy_s;
  logic [7:0]       pd_s;
  logic             wr_hit;
  logic             rd_hit;
  logic             fwd_wr;
  logic             ecp_fwd;

  ////////////////////////////////////////////////////////////////////////
  ppx_sync #(.WIDTH(10)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      ({!peripheral_ack, busy, pd_in}),
    .dout     ({ack_n_s, busy_s, pd_s})
  );

  // sync resets low; inverted so ack idles high, no false edge after reset
  assign ack_s = !ack_n_s;

  ////////////////////////////////////////////////////////////////////////
  assign wr_hit = !parallel_port_select_n && !cpu_wr_n;
  assign rd_hit = !parallel_port_select_n && !cpu_rd_n;
  assign bus_buffer_dir = !rd_hit;
  assign fwd_wr = wr_hit && (state_r == PPX_IDLE) && !dir_r
                  && ((register_select_lines == REG_DATA)
                   || (register_select_lines == REG_ADDR));
  assign ecp_fwd = (state_r == PPX_EF_WAIT) || (state_r == PPX_EF_STB)
                   || (state_r == PPX_EF_REL);

  // control register; reset lands in compatibility mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= PPX_MODE_COMPAT;
      dir_r  <= 1'b0;
    end else if (wr_hit && register_select_lines == REG_CTRL) begin
      mode_r <= ppx_mode_t'(cpu_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      dir_r  <= cpu_wdata[CTRL_DIR];
    end
  end

  // outgoing byte and its address/data tag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_out <= 8'h00;
      tag_r  <= 1'b0;
    end else if (fwd_wr) begin
      pd_out <= cpu_wdata;
      tag_r  <= (register_select_lines == REG_ADDR);
    end
  end

  // data lines turn round only for reverse 1284 modes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_oe <= 1'b1;
    end else begin
      pd_oe <= !(dir_r && mode_r != PPX_MODE_COMPAT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // handshake sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PPX_IDLE;
    end else begin
      case (state_r)
        PPX_IDLE: begin
          if (fwd_wr) begin
            case (mode_r)
              PPX_MODE_ECP: state_r <= PPX_EF_WAIT;
              PPX_MODE_EPP: state_r <= PPX_P_STB;
              default:      state_r <= PPX_C_WAIT;
            endcase
          end else if (wr_hit && register_select_lines == REG_CTRL
                       && cpu_wdata[CTRL_NEG]
                       && mode_r == PPX_MODE_COMPAT) begin
            state_r <= PPX_NEG_REQ;
          end else if (dir_r && !rxv_r && mode_r == PPX_MODE_ECP) begin
            state_r <= PPX_ER_REQ;
          end else if (dir_r && !rxv_r && mode_r == PPX_MODE_EPP) begin
            state_r <= PPX_P_STB;
          end
        end
        // no compatibility or ecp byte goes out while the printer says busy; epp strobes without waiting
        PPX_C_WAIT:  if (!busy_s) state_r <= PPX_C_STB;
        PPX_C_STB:   if (cnt_r == CNT_W'(STROBE_CYC - 1)) state_r <= PPX_C_ACK;
        PPX_C_ACK:   if (!ack_s) state_r <= PPX_C_ACKR;
        PPX_C_ACKR:  if (ack_s) state_r <= PPX_IDLE;
        PPX_NEG_REQ: if (!ack_s) state_r <= PPX_IDLE;
        PPX_EF_WAIT: if (!busy_s) state_r <= PPX_EF_STB;
        PPX_EF_STB:  if (busy_s) state_r <= PPX_EF_REL;
        PPX_EF_REL:  if (!busy_s) state_r <= PPX_IDLE;
        PPX_ER_REQ:  if (!ack_s) state_r <= PPX_ER_REL;
        PPX_ER_REL:  if (ack_s) state_r <= PPX_IDLE;
        PPX_P_STB:   if (busy_s) state_r <= PPX_P_REL;
        PPX_P_REL:   if (!busy_s) state_r <= PPX_IDLE;
        default:     state_r <= PPX_IDLE;
      endcase
    end
  end

  // compatibility strobe width counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_r == PPX_C_STB) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end else begin
      cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line drive decoded from the sequencer state
  always_comb begin
    strobe_n            = 1'b1;
    host_feed_request_n = 1'b1;
    host_select_request = (mode_r != PPX_MODE_COMPAT);
    case (state_r)
      PPX_C_STB:   strobe_n = 1'b0;
      PPX_NEG_REQ: begin
        host_feed_request_n = 1'b0;
        host_select_request = 1'b1;
      end
      PPX_EF_WAIT, PPX_EF_REL: host_feed_request_n = !tag_r;
      PPX_EF_STB: begin
        strobe_n            = 1'b0;
        host_feed_request_n = !tag_r;
      end
      PPX_ER_REQ:  host_feed_request_n = 1'b0;
      // address cycles strobe on select, data cycles on feed
      PPX_P_STB: begin
        strobe_n            = dir_r;
        host_feed_request_n = tag_r;
        host_select_request = !tag_r;
      end
      default: begin
        strobe_n = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // reverse byte capture; a new byte beats a same-cycle read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r  <= 8'h00;
      cmd_r <= 1'b0;
      rxv_r <= 1'b0;
    end else if ((state_r == PPX_ER_REQ && !ack_s)
                 || (state_r == PPX_P_STB && dir_r && busy_s)) begin
      rx_r  <= pd_s;
      cmd_r <= (state_r == PPX_ER_REQ) && !busy_s;
      rxv_r <= 1'b1;
    end else if (rd_hit && register_select_lines == REG_DATA) begin
      rxv_r <= 1'b0;
    end
  end

  // epp interrupt on ack rising edge; set wins over status read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_d_r <= 1'b1;
      irq_r   <= 1'b0;
    end else begin
      ack_d_r <= ack_s;
      if (mode_r == PPX_MODE_EPP && ack_s && !ack_d_r) begin
        irq_r <= 1'b1;
      end else if (rd_hit && register_select_lines == REG_STATUS) begin
        irq_r <= 1'b0;
      end
    end
  end

  // negotiation answered flag, cleared by the next control write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_done_r <= 1'b0;
    end else if (state_r == PPX_NEG_REQ && !ack_s) begin
      neg_done_r <= 1'b1;
    end else if (wr_hit && register_select_lines == REG_CTRL) begin
      neg_done_r <= 1'b0;
    end
  end

  // read data registered; unmapped selects read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (rd_hit) begin
      cpu_rdata <= 8'h00;
      case (register_select_lines)
        REG_DATA:   cpu_rdata <= rx_r;
        REG_STATUS: begin
          cpu_rdata[ST_BUSY] <= busy_s;
          cpu_rdata[ST_ACK]  <= ack_s;
          cpu_rdata[ST_RXV]  <= rxv_r;
          cpu_rdata[ST_IRQ]  <= irq_r;
          cpu_rdata[ST_XFER] <= (state_r != PPX_IDLE);
          cpu_rdata[ST_CMD]  <= cmd_r;
          cpu_rdata[ST_NEG]  <= neg_done_r;
        end
        REG_CTRL: begin
          cpu_rdata[CTRL_MODE_MSB:CTRL_MODE_LSB] <= mode_r;
          cpu_rdata[CTRL_DIR] <= dir_r;
        end
        default: cpu_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_BUF_DIR: assert property (cpu_rd_n |-> bus_buffer_dir)
    else $error("buffer direction low without a read");
  AST_NEG_DRIVE: assert property (state_r == PPX_NEG_REQ
      |-> !host_feed_request_n && host_select_request)
    else $error("negotiation lines wrong");
  AST_NEG_RELEASE: assert property (state_r == PPX_NEG_REQ && !ack_s
      |=> host_feed_request_n ##0 neg_done_r)
    else $error("feed not released after ack");
  AST_ECP_REV: assert property (state_r == PPX_ER_REQ && !ack_s
      |=> host_feed_request_n && rxv_r && rx_r == $past(pd_s))
    else $error("reverse byte not taken");
  AST_ECP_TAG: assert property (ecp_fwd
      |-> host_feed_request_n == !tag_r)
    else $error("ecp forward tag wrong");
  AST_ECP_BUSY: assert property (state_r == PPX_EF_STB && busy_s
      |=> strobe_n)
    else $error("strobe held after busy");
  AST_EPP_IRQ: assert property (mode_r == PPX_MODE_EPP
      && ack_s && !$past(ack_s) |=> irq_r)
    else $error("epp interrupt missed");
  AST_EPP_FEED: assert property (state_r == PPX_P_STB && !tag_r
      |-> !host_feed_request_n && host_select_request)
    else $error("epp data strobe missing");
  AST_SEL_GATE: assert property (parallel_port_select_n
      |=> $stable(mode_r) && $stable(dir_r))
    else $error("control changed while deselected");
  AST_CTRL_READ: assert property (rd_hit
      && register_select_lines == REG_CTRL
      |=> cpu_rdata[CTRL_MODE_MSB:CTRL_MODE_LSB] == $past(mode_r))
    else $error("control readback wrong");
  AST_C_STB: assert property ($fell(strobe_n) && mode_r == PPX_MODE_COMPAT
      |-> !strobe_n [*8] ##0 !$past(busy_s, 8))
    else $error("compat strobe short or sent while busy");

  COV_NEG:  cover property (state_r == PPX_NEG_REQ ##1 neg_done_r);
  COV_REV:  cover property (state_r == PPX_ER_REL ##1 state_r == PPX_IDLE);
  COV_IRQ:  cover property ($rose(irq_r));
  COV_COMP: cover property (state_r == PPX_C_ACKR ##1 state_r == PPX_IDLE);

endmodule : ppx_host
`default_nettype wire

// ---- ppx_pkg.sv ----
// constants, types and encodings for the parallel host handshake block
package ppx_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_NS     = 500;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  typedef enum logic [1:0] {
    PPX_MODE_COMPAT = 2'b00,
    PPX_MODE_ECP    = 2'b01,
    PPX_MODE_EPP    = 2'b10
  } ppx_mode_t;

  // register indices on register_select_lines
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CTRL   = 3'h2;
  localparam logic [2:0] REG_ADDR   = 3'h3;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 1;
  localparam int CTRL_DIR      = 2;
  localparam int CTRL_NEG      = 3;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_ACK  = 1;
  localparam int ST_RXV  = 2;
  localparam int ST_IRQ  = 3;
  localparam int ST_XFER = 4;
  localparam int ST_CMD  = 5;
  localparam int ST_NEG  = 6;

  typedef enum logic [3:0] {
    PPX_IDLE    = 4'h0,
    PPX_C_WAIT  = 4'h1,
    PPX_C_STB   = 4'h2,
    PPX_C_ACK   = 4'h3,
    PPX_C_ACKR  = 4'h4,
    PPX_NEG_REQ = 4'h5,
    PPX_EF_WAIT = 4'h6,
    PPX_EF_STB  = 4'h7,
    PPX_EF_REL  = 4'h8,
    PPX_ER_REQ  = 4'h9,
    PPX_ER_REL  = 4'ha,
    PPX_P_STB   = 4'hb,
    PPX_P_REL   = 4'hc
  } ppx_state_t;

endpackage : ppx_pkg

// ---- ppx_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ppx_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // raw and filtered level
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : ppx_sync
`default_nettype wire

// ---- ppx_printer.sv ----
// printer side model answering the host handshake lines
`timescale 1ns/1ps
`default_nettype none
module ppx_printer (
  // clock
  input  wire logic       core_clk,
  // host lines
  input  wire logic       strobe_n,
  input  wire logic       feed_n,
  input  wire logic       sel,
  // bench controls
  input  wire logic [1:0] mode,
  input  wire logic       rev,
  input  wire logic [7:0] rev_byte,
  input  wire logic       rev_cmd,
  input  wire logic       hold_busy,
  input  wire logic       irq_req,
  input  wire logic [2:0] lag,
  // peripheral lines
  output logic            ack,
  output logic            busy,
  output logic      [7:0] pd_in
);
  // at least two cycles: a one-cycle pulse never passes the input filter
  task automatic pause();
    repeat (lag + 2) @(posedge core_clk);
  endtask : pause

  initial begin
    ack = 1'b1;
    busy = 1'b0;
    pd_in = 8'h3c;
    forever begin
      @(posedge core_clk);
      busy <= hold_busy;
      ack <= (mode == 2'h2) ? irq_req : 1'b1;
      // released data lines never hold the old byte
      pd_in <= ~pd_in;
      if (mode == 2'h2 && (!feed_n || !sel)) begin
        // read cycle: put the reverse byte on the lines
        if (strobe_n) pd_in <= rev_byte;
        pause();
        busy <= 1'b1;
        while (!feed_n || !sel) @(posedge core_clk);
        pause();
      end else if (mode == 2'h1 && rev && !feed_n) begin
        pd_in <= rev_byte;
        busy <= !rev_cmd;
        pause();
        ack <= 1'b0;
        while (!feed_n) @(posedge core_clk);
        ack <= 1'b1;
      end else if (!strobe_n) begin
        busy <= 1'b1;
        while (!strobe_n) @(posedge core_clk);
        pause();
        if (mode == 2'h0) begin
          ack <= 1'b0;
          pause();
          ack <= 1'b1;
        end
      end else if (mode == 2'h0 && !feed_n && sel) begin
        pause();
        ack <= 1'b0;
        while (!feed_n) @(posedge core_clk);
        ack <= 1'b1;
      end
    end
  end
endmodule : ppx_printer
`default_nettype wire

// ---- ppx_host_bench.sv ----
// self-checking bench for the parallel host handshake block
`timescale 1ns/1ps
`default_nettype none
module ppx_host_bench;
  import ppx_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sel_n = 1'b1;
  logic       wr_n = 1'b1;
  logic       rd_n = 1'b1;
  logic [2:0] rs = 3'h0;
  logic [2:0] lag = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rev_byte = 8'h00;
  logic [7:0] rdata, pd_in, pd_out, rd_v, old;
  logic       bdir, ack, busy, pd_oe, strobe_n, feed_n, hsel, ev;
  logic       rev = 1'b0;
  logic       rev_cmd = 1'b0;
  logic       hold_busy = 1'b0;
  logic       irq_req = 1'b0;
  logic       ps_n = 1'b1;
  logic       pf_n = 1'b1;
  logic       psel = 1'b0;
  logic [8:0] got;
  logic [8:0] exp_q[$];
  ppx_mode_t  mode = PPX_MODE_COMPAT;
  int         error_cnt = 0;
  int         check_count = 0;

  always #2.5 core_clk = ~core_clk;

  ppx_host i_ppx_host (.core_clk(core_clk), .rst_n(rst_n),
    .parallel_port_select_n(sel_n), .register_select_lines(rs),
    .cpu_wr_n(wr_n), .cpu_rd_n(rd_n), .cpu_wdata(wdata),
    .cpu_rdata(rdata), .bus_buffer_dir(bdir), .peripheral_ack(ack),
    .busy(busy), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .strobe_n(strobe_n), .host_feed_request_n(feed_n),
    .host_select_request(hsel));

  ppx_printer i_ppx_printer (.core_clk(core_clk), .strobe_n(strobe_n),
    .feed_n(feed_n), .sel(hsel), .mode(mode), .rev(rev),
    .rev_byte(rev_byte), .rev_cmd(rev_cmd), .hold_busy(hold_busy),
    .irq_req(irq_req), .lag(lag), .ack(ack), .busy(busy), .pd_in(pd_in));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [2:0] a, input logic [7:0] d,
                    input logic sn);
    @(negedge core_clk);
    sel_n = sn;
    rs = a;
    wdata = d;
    wr_n = 1'b0;
    @(negedge core_clk);
    wr_n = 1'b1;
    sel_n = 1'b1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sel_n = 1'b0;
    rs = a;
    rd_n = 1'b0;
    #1 check(9'(bdir), 9'h0);
    @(negedge core_clk);
    rd_n = 1'b1;
    sel_n = 1'b1;
    d = rdata;
    #1 check(9'(bdir), 9'h1);
  endtask : rd

  task automatic poll(input int b, input logic val);
    int n;
    for (n = 0; n < 2000; n++) begin
      rd(REG_STATUS, rd_v);
      if (rd_v[b] === val) break;
    end
    if (n == 2000) begin
      error_cnt++;
      print_verdict();
    end
  endtask : poll

  // a = 1 sends an address or command byte
  task automatic send(input logic a);
    logic [7:0] d;
    d = 8'($urandom);
    lag = 3'($urandom);
    exp_q.push_back({a, d});
    wr(a ? REG_ADDR : REG_DATA, d, 1'b0);
    poll(ST_XFER, 1'b0);
  endtask : send

  //////////////////////////////////////////////////////////////////////////
  // forward byte monitor: every strobe must carry the next queued byte
  always @(posedge core_clk) begin
    ps_n <= strobe_n;
    pf_n <= feed_n;
    psel <= hsel;
    ev = 1'b0;
    if (mode != PPX_MODE_EPP && !rev && ps_n && !strobe_n) begin
      ev = 1'b1;
      got = {!feed_n, pd_out};
    end else if (mode == PPX_MODE_EPP && !rev
                 && ((pf_n && !feed_n) || (psel && !hsel))) begin
      ev = 1'b1;
      got = {!hsel, pd_out};
    end
    if (ev && exp_q.size() == 0)
      check(got, ~got);
    else if (ev)
      check(got, exp_q.pop_front());
  end

  initial begin
    void'($urandom(3381));
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    rd(REG_CTRL, rd_v);
    check(9'(rd_v), 9'h0);
    check(9'(pd_oe), 9'h1);
    rd(3'h5, rd_v);
    check(9'(rd_v), 9'h0);
    wr(REG_DATA, 8'ha5, 1'b1);
    repeat (20) @(negedge core_clk);
    rd(REG_STATUS, rd_v);
    check(9'(rd_v[ST_XFER]), 9'h0);
    repeat (3) send(1'b0);
    // a held busy must keep the byte back
    hold_busy = 1'b1;
    repeat (4) @(negedge core_clk);
    exp_q.push_back(9'h081);
    wr(REG_DATA, 8'h81, 1'b0);
    repeat (200) @(negedge core_clk);
    check(9'(strobe_n), 9'h1);
    hold_busy = 1'b0;
    poll(ST_XFER, 1'b0);
    wr(REG_CTRL, 8'h08, 1'b0);
    poll(ST_NEG, 1'b1);
    check(9'(feed_n), 9'h1);
    wr(REG_CTRL, 8'h01, 1'b0);
    mode = PPX_MODE_ECP;
    send(1'b0);
    send(1'b1);
    send(1'b0);
    rev_byte = 8'($urandom);
    wr(REG_CTRL, 8'h05, 1'b0);
    rev = 1'b1;
    for (int i = 0; i < 2; i++) begin
      poll(ST_RXV, 1'b1);
      check(9'(rd_v[ST_CMD]), 9'(rev_cmd));
      check(9'(pd_oe), 9'h0);
      old = rev_byte;
      rev_byte = 8'($urandom);
      rev_cmd = ~rev_cmd;
      rd(REG_DATA, rd_v);
      check(9'(rd_v), 9'(old));
    end
    repeat (30) @(negedge core_clk);
    wr(REG_CTRL, 8'h02, 1'b0);
    mode = PPX_MODE_EPP;
    rev = 1'b0;
    send(1'b0);
    send(1'b1);
    irq_req = 1'b1;
    repeat (10) @(negedge core_clk);
    irq_req = 1'b0;
    rd(REG_STATUS, rd_v);
    check(9'(rd_v[ST_IRQ]), 9'h1);
    rd(REG_STATUS, rd_v);
    check(9'(rd_v[ST_IRQ]), 9'h0);
    // epp reverse: drop the stale ecp byte, then read one back
    rd(REG_DATA, rd_v);
    rev_byte = 8'($urandom);
    wr(REG_CTRL, 8'h06, 1'b0);
    rev = 1'b1;
    poll(ST_RXV, 1'b1);
    check(9'(pd_oe), 9'h0);
    rd(REG_DATA, rd_v);
    check(9'(rd_v), 9'(rev_byte));
    check(9'(exp_q.size()), 9'h0);
    print_verdict();
  end
endmodule : ppx_host_bench
`default_nettype wire
